//--- rtl/tsb_status_buffer.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - six bytes delivered, byte 0 first, ascending
// - byte 0 bit 7 flags any other set
// - bit 6 no cartridge or removed while lit
// - bit 5 drive absent at function start
// - bit 4 write on protected cartridge
// - bit 3 end of last track reached
// - bits 2 and 1 unrecoverable errors
// - bit 0 file mark or image end
// - byte 1 bit 6 illegal function code
// - byte 1 bit 5 no data found
// - byte 1 bit 4 eight-plus read retries
// - byte 1 bit 3 BOT, bit 0 power-on
// - bytes 4-5 underrun count, high first
// - status read clears byte 0 bits 3-0, all of byte 1 and counters
// - data-error flags persist from previous read
module tsb_status_buffer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire tsb_pkg::tsb_event_type events,
  input wire logic [tsb_pkg::TSB_ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tsb_pkg::TSB_DATA_WIDTH-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tsb_pkg::TSB_ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tsb_pkg::TSB_DATA_WIDTH-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic recordTaken
);
  import tsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // write channel
  logic awHave;
  logic wHave;
  logic [TSB_ADDR_WIDTH-1:0] awAddr;
  logic [TSB_DATA_WIDTH-1:0] wData;
  logic [3:0] wStrb;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire next_awHave = awHave || awTake;
  wire next_wHave = wHave || wTake;
  wire [TSB_ADDR_WIDTH-1:0] next_awAddr = awTake ? s_axi_awaddr : awAddr;
  wire [TSB_DATA_WIDTH-1:0] next_wData = wTake ? s_axi_wdata : wData;
  wire [3:0] next_wStrb = wTake ? s_axi_wstrb : wStrb;
  wire writeDo = awHave && wHave && !s_axi_bvalid;
  wire wrControl = writeDo && (awAddr == TSB_ADDR_CONTROL);
  wire wrMapped = wrControl;
  wire takeRecord = wrControl && wStrb[0] && wData[TSB_CTRL_TAKE_BIT];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TSB_RESP_OKAY;
    end else begin
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      if (writeDo) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? TSB_RESP_OKAY : TSB_RESP_SLVERR;
      end else begin
        awHave <= next_awHave;
        wHave <= next_wHave;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      // ready only while the slot is empty, so one write at a time
      s_axi_awready <= !next_awHave && !writeDo && !s_axi_bvalid;
      s_axi_wready <= !next_wHave && !writeDo && !s_axi_bvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  logic [7:0] flags0;
  logic [7:0] flags1;
  logic [7:0] prevErr0;
  logic [7:0] prevErr1;
  logic [TSB_COUNT_WIDTH-1:0] retryCount;
  logic [TSB_COUNT_WIDTH-1:0] underrunCount;

  wire [7:0] set0 = {1'b0,
    events.noCartridge || events.cartRemovedLit,
    events.driveAbsent,
    events.writeProtHit,
    events.endOfLastTrack,
    events.dataError,
    events.fatalError,
    events.fileMark};
  wire [7:0] set1 = {1'b0,
    events.illegalFunction,
    events.noDataFound,
    events.manyRetries,
    events.atBot,
    3'b000};

  // read clears its bits, the previous read's errors come back, new events win
  wire [7:0] keep0 = takeRecord ? ~TSB_B0_CLEAR_MASK : 8'hff;
  wire [7:0] keep1 = takeRecord ? ~TSB_B1_CLEAR_MASK : 8'hff;
  wire [7:0] reload0 = takeRecord ? prevErr0 : 8'h00;
  wire [7:0] reload1 = takeRecord ? prevErr1 : 8'h00;
  wire [7:0] next_flags0 = ((flags0 & keep0) | reload0 | set0) & 8'h7f;
  wire [7:0] next_flags1 = ((flags1 & keep1) | reload1 | set1) & TSB_B1_USED_MASK;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags0 <= TSB_B0_RESET;
      flags1 <= TSB_B1_RESET;
      prevErr0 <= 8'h00;
      prevErr1 <= 8'h00;
    end else begin
      flags0 <= next_flags0;
      flags1 <= next_flags1;
      if (takeRecord) begin
        prevErr0 <= flags0 & TSB_B0_ERR_MASK;
        prevErr1 <= flags1 & TSB_B1_ERR_MASK;
      end
    end
  end

  tsb_counter #(.WIDTH(TSB_COUNT_WIDTH)) retryCounter (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inc(events.retryPulse),
    .clear(takeRecord),
    .count(retryCount)
  );

  tsb_counter #(.WIDTH(TSB_COUNT_WIDTH)) underrunCounter (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inc(events.underrunPulse),
    .clear(takeRecord),
    .count(underrunCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // live record and snapshot
  wire anyByte0 = |flags0[6:0];
  tsb_record_type liveRecord;
  assign liveRecord.byte0 = {anyByte0, flags0[6:0]};
  assign liveRecord.byte1 = {anyByte0, flags1[6:0]};
  assign liveRecord.byte2 = retryCount[15:8];
  assign liveRecord.byte3 = retryCount[7:0];
  assign liveRecord.byte4 = underrunCount[15:8];
  assign liveRecord.byte5 = underrunCount[7:0];

  // snapshot taken in the same edge that clears, so nothing slips between
  tsb_record_type record;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      record <= '0;
      recordTaken <= 1'b0;
    end else begin
      recordTaken <= takeRecord;
      if (takeRecord) begin
        record <= liveRecord;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel, byte 0 in the lowest lane so memory order is ascending
  tsb_read_state_type readState;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire isLo = s_axi_araddr == TSB_ADDR_RECORD_LO;
  wire isHi = s_axi_araddr == TSB_ADDR_RECORD_HI;
  wire isLive = s_axi_araddr == TSB_ADDR_LIVE;
  wire isCtrl = s_axi_araddr == TSB_ADDR_CONTROL;
  wire [31:0] loWord = {record.byte3, record.byte2, record.byte1, record.byte0};
  wire [31:0] hiWord = {16'h0000, record.byte5, record.byte4};
  wire [31:0] liveWord = {16'h0000, liveRecord.byte1, liveRecord.byte0};
  wire [31:0] next_rdata = isLo ? loWord :
                           isHi ? hiWord :
                           isLive ? liveWord : 32'h00000000;
  wire [1:0] next_rresp = (isLo || isHi || isLive || isCtrl) ? TSB_RESP_OKAY : TSB_RESP_SLVERR;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readState <= TSB_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= TSB_RESP_OKAY;
    end else begin
      case (readState)
        TSB_RD_IDLE: begin
          s_axi_arready <= !arTake;
          if (arTake) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= 1'b1;
            readState <= TSB_RD_ANSWER;
          end
        end
        TSB_RD_ANSWER: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            readState <= TSB_RD_IDLE;
          end
        end
        default: begin
          readState <= TSB_RD_IDLE;
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- rtl/tsb_pkg.sv
package tsb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the bus
  localparam logic [3:0] TSB_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] TSB_ADDR_RECORD_LO = 4'h4;
  localparam logic [3:0] TSB_ADDR_RECORD_HI = 4'h8;
  localparam logic [3:0] TSB_ADDR_LIVE = 4'hc;
  localparam int TSB_ADDR_WIDTH = 4;
  localparam int TSB_DATA_WIDTH = 32;

  // control register: writing one here takes a status record
  localparam int TSB_CTRL_TAKE_BIT = 0;

  // axi responses
  localparam logic [1:0] TSB_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSB_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // status byte 0 bit positions
  localparam int TSB_B0_ANY = 7;
  localparam int TSB_B0_NO_CART = 6;
  localparam int TSB_B0_NO_DRIVE = 5;
  localparam int TSB_B0_WRITE_PROT = 4;
  localparam int TSB_B0_END_TRACK = 3;
  localparam int TSB_B0_DATA_ERR = 2;
  localparam int TSB_B0_FATAL_ERR = 1;
  localparam int TSB_B0_FILE_MARK = 0;
  // status byte 1 bit positions
  localparam int TSB_B1_ANY = 7;
  localparam int TSB_B1_ILLEGAL = 6;
  localparam int TSB_B1_NO_DATA = 5;
  localparam int TSB_B1_RETRIES = 4;
  localparam int TSB_B1_AT_BOT = 3;
  localparam int TSB_B1_POWER_ON = 0;

  // masks over the stored flags (bit 7 of each byte is derived, never stored)
  localparam logic [7:0] TSB_B0_CLEAR_MASK = 8'h0f;
  localparam logic [7:0] TSB_B1_CLEAR_MASK = 8'hff;
  localparam logic [7:0] TSB_B0_ERR_MASK = 8'h07;
  localparam logic [7:0] TSB_B1_ERR_MASK = 8'h30;
  localparam logic [7:0] TSB_B1_USED_MASK = 8'h79;
  localparam logic [7:0] TSB_B0_RESET = 8'h00;
  localparam logic [7:0] TSB_B1_RESET = 8'h01;

  localparam int TSB_COUNT_WIDTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // condition reports from the tape drive's status source, same clock
  typedef struct packed {
    logic noCartridge;
    logic cartRemovedLit;
    logic driveAbsent;
    logic writeProtHit;
    logic endOfLastTrack;
    logic dataError;
    logic fatalError;
    logic fileMark;
    logic illegalFunction;
    logic noDataFound;
    logic manyRetries;
    logic atBot;
    logic retryPulse;
    logic underrunPulse;
  } tsb_event_type;

  // six-byte record, byte 0 first
  typedef struct packed {
    logic [7:0] byte5;
    logic [7:0] byte4;
    logic [7:0] byte3;
    logic [7:0] byte2;
    logic [7:0] byte1;
    logic [7:0] byte0;
  } tsb_record_type;

  typedef enum logic [1:0] {
    TSB_RD_IDLE = 2'b00,
    TSB_RD_ANSWER = 2'b01
  } tsb_read_state_type;

endpackage

//--- rtl/tsb_counter.sv
`timescale 1ns/1ps
module tsb_counter #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic inc,
  input wire logic clear,
  output logic [WIDTH-1:0] count
);
  wire atTop = &count;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (clear) begin
      // an increment in the clearing cycle is kept, not lost
      count <= inc ? WIDTH'(1) : '0;
    end else if (inc && !atTop) begin
      // saturate rather than wrap, so a huge count never reads as small
      count <= count + WIDTH'(1);
    end
  end
endmodule

//--- verification/tsb_status_buffer_sva.sv
`timescale 1ns/1ps
module tsb_status_buffer_sva
  import tsb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic recordTaken
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire arTake = s_axi_arvalid && s_axi_arready;
  ////////////////////////////////////////////////////////////////////////////
  a_take_single: assert property (recordTaken |=> !recordTaken)
    else $error("take pulse longer than one cycle");
  // the response rises on the same edge as the take pulse, so both stand together
  a_take_after_ok: assert property (recordTaken |-> s_axi_bvalid &&
    s_axi_bresp == TSB_RESP_OKAY) else $error("take without okay response");
  a_bvalid_gone: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_read_answer: assert property (arTake |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_no_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  // bit 7 of both bytes mirrors byte 0 only, reserved bits stay low
  a_live_any: assert property (arTake && s_axi_araddr == TSB_ADDR_LIVE |=>
    s_axi_rdata[7] == |s_axi_rdata[6:0] && s_axi_rdata[15] == s_axi_rdata[7] &&
    s_axi_rdata[10:9] == 2'h0 && s_axi_rdata[31:16] == 16'h0) else $error("live bytes bad");
  a_rec_any: assert property (arTake && s_axi_araddr == TSB_ADDR_RECORD_LO |=>
    s_axi_rdata[7] == |s_axi_rdata[6:0] && s_axi_rdata[15] == s_axi_rdata[7] &&
    s_axi_rdata[10:9] == 2'h0) else $error("record flag bytes bad");
  a_hi_upper: assert property (arTake && s_axi_araddr == TSB_ADDR_RECORD_HI |=>
    s_axi_rdata[31:16] == 16'h0 && s_axi_rresp == TSB_RESP_OKAY) else $error("record high bad");
  a_bad_read: assert property (arTake && s_axi_araddr[1:0] != 2'h0 |=>
    s_axi_rresp == TSB_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read bad");
endmodule
bind tsb_status_buffer tsb_status_buffer_sva tsb_status_buffer_sva_i (.*);

//--- verification/tsb_drive_model.sv
`timescale 1ns/1ps
module tsb_drive_model (
  input wire logic sys_clk,
  output tsb_pkg::tsb_event_type events
);
  import tsb_pkg::*;
  initial events = '0;
  // reports are levels held n cycles; each high cycle counts once for the pulse bits
  task automatic raise(input logic [13:0] m, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      events <= m;
    end
    @(posedge sys_clk);
    events <= '0;
  endtask
endmodule

//--- verification/test_tsb_status_buffer.sv
`timescale 1ns/1ps
module test_tsb_status_buffer;
  import tsb_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic recordTaken, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  tsb_event_type events;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [33:0] rdQ[$];
  logic [1:0] wrQ[$];
  // p0 and p1 hold the error bits seen at the last take, reloaded at the next one
  logic [7:0] m0, m1, p0, p1;
  logic [15:0] mr, mu;
  int errTotal = 0;
  int checkCount = 0;
  int n, k;
  logic [15:0] evm [12] = '{16'h0040, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004,
    16'h0002, 16'h0001, 16'h4000, 16'h2000, 16'h1000, 16'h0800};
  tsb_status_buffer tsb_status_buffer_i (.*);
  tsb_drive_model tsb_drive_model_i (.*);
  always #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] live();
    return {|m0[6:0], m1[6:0], |m0[6:0], m0[6:0]};
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checkCount++;
    if (g !== e) begin
      errTotal++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, {wrQ.pop_front(), 32'h0});
  end
  // released address and data lines carry the inverse, never a stale value
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    wrQ.push_back(r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle budget here: only the watchdog ends a wait that never answers
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rdQ.push_back(e);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    {m1, m0, mr, mu} = {8'h01, 40'h0};
    {p1, p0} = 16'h0000;
    repeat (2) @(posedge sys_clk);
  endtask
  // errors seen at one take come back after the next take; counters and low flags cleared
  task automatic take();
    logic [15:0] v;
    v = live();
    wr(TSB_ADDR_CONTROL, 32'h1, TSB_RESP_OKAY);
    rd(TSB_ADDR_RECORD_LO, {TSB_RESP_OKAY, mr[7:0], mr[15:8], v});
    rd(TSB_ADDR_RECORD_HI, {TSB_RESP_OKAY, 16'h0, mu[7:0], mu[15:8]});
    m0 = m0 & 8'h70 | p0;
    m1 = p1;
    p0 = v[7:0] & 8'h07;
    p1 = v[15:8] & 8'h30;
    {mr, mu} = 32'h0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    errTotal++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h57678f97));
    rst();
    rd(TSB_ADDR_LIVE, {TSB_RESP_OKAY, 16'h0, live()});
    take();
    wr(TSB_ADDR_RECORD_LO, 32'h1, TSB_RESP_SLVERR);
    wr(4'h2, 32'h1, TSB_RESP_SLVERR);
    rd(4'h2, {TSB_RESP_SLVERR, 32'h0});
    wr(TSB_ADDR_CONTROL, 32'h0, TSB_RESP_OKAY);
    for (k = 0; k < 12; k++) begin
      tsb_drive_model_i.raise(14'h2000 >> k, 1);
      {m1, m0} = {m1, m0} | evm[k];
      rd(TSB_ADDR_LIVE, {TSB_RESP_OKAY, 16'h0, live()});
    end
    take();
    take();
    rd(TSB_ADDR_LIVE, {TSB_RESP_OKAY, 16'h0, live()});
    rst();
    n = $urandom_range(40, 1);
    k = $urandom_range(40, 1);
    tsb_drive_model_i.raise(14'h0002, n);
    tsb_drive_model_i.raise(14'h0001, k);
    mr = n[15:0];
    mu = k[15:0];
    take();
    take();
    end_sim();
  end
endmodule
